//--- verilog/rsie_defines.vh
`ifndef RSIE_DEFINES_VH
`define RSIE_DEFINES_VH
// ==========================================
// opcodes
`define RSIE_OP_HALT 8'hdf
`define RSIE_OP_NOP 8'hc0
`define RSIE_OP_TXCAL 8'hc1
`define RSIE_OP_RXON 8'hc2
`define RSIE_OP_TXON 8'hc3
`define RSIE_OP_TXCCA 8'hc4
`define RSIE_OP_OFF 8'hc5
`define RSIE_OP_FLRX 8'hc6
`define RSIE_OP_FLTX 8'hc7
`define RSIE_OP_ACK 8'hc8
`define RSIE_OP_ACKP 8'hc9
`define RSIE_OP_IHALT 8'hff
`define RSIE_OP_ISTART 8'hfe
`define RSIE_OP_ITXCAL 8'he1
// immediate strobe class: 0xe1..0xe9 maps to 0xc1..0xc9
`define RSIE_IMM_STRB_HI 4'he
`define RSIE_PRG_STRB_HI 4'hc
`define RSIE_STRB_LO_MIN 4'h1
`define RSIE_STRB_LO_MAX 4'h9
// ==========================================
// strobe vector bit positions
`define RSIE_STRB_W 9
`define RSIE_SB_TXCAL 0
`define RSIE_SB_RXON 1
`define RSIE_SB_TXON 2
`define RSIE_SB_TXCCA 3
`define RSIE_SB_OFF 4
`define RSIE_SB_FLRX 5
`define RSIE_SB_FLTX 6
`define RSIE_SB_ACK 7
`define RSIE_SB_ACKP 8
`define RSIE_ZERO8 8'h00
`endif

//--- verilog/rsie_strobe_dec.v
`timescale 1ns/1ps
`include "rsie_defines.vh"
// ==========================================
// maps a strobe opcode low nibble to a one-hot strobe vector
module rsie_strobe_dec (
	// opcode
	input wire [7:0] opcode,
	// decoded
	output reg is_strobe,
	output reg [`RSIE_STRB_W-1:0] strobe_vec
);
	always @* begin
		is_strobe = 1'b0;
		strobe_vec = {`RSIE_STRB_W{1'b0}};
		if ((opcode[7:4] == `RSIE_PRG_STRB_HI ||
			opcode[7:4] == `RSIE_IMM_STRB_HI) &&
			opcode[3:0] >= `RSIE_STRB_LO_MIN &&
			opcode[3:0] <= `RSIE_STRB_LO_MAX) begin
			is_strobe = 1'b1;
			strobe_vec[opcode[3:0] - `RSIE_STRB_LO_MIN] = 1'b1;
		end
	end
endmodule

//--- verilog/rsie_imem.v
`timescale 1ns/1ps
`include "rsie_defines.vh"
// ==========================================
// instruction memory with write pointer and clear
module rsie_imem #(
	parameter DEPTH = 24,
	parameter AW = 5
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// write side
	input wire wr_en,
	input wire [7:0] wr_data,
	input wire clear,
	// read side
	input wire [AW-1:0] rd_addr,
	output wire [7:0] rd_data,
	output wire [AW-1:0] count
);
	reg [7:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wptr_q;
	integer i;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= {AW{1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= `RSIE_ZERO8;
		end else if (clear) begin
			wptr_q <= {AW{1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= `RSIE_ZERO8;
		end else if (wr_en && wptr_q < DEPTH[AW-1:0]) begin
			mem_q[wptr_q] <= wr_data;
			wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
		end
	end
	// out-of-range reads return a halt so a runaway program stops
	assign rd_data = (rd_addr < wptr_q) ? mem_q[rd_addr] : `RSIE_OP_HALT;
	assign count = wptr_q;
endmodule

//--- verilog/rsie_exec.v
`timescale 1ns/1ps
`include "rsie_defines.vh"
// How it works
// - halt opcode stops, zeroes pc and pointer
// - halt clears memory, label, raises stopped flag
// - nop only advances the pc
// - tx calibrate strobe, test use only
// - receive-on opcode pulses receive-on strobe
// - strobes hold pc until radio acknowledges
// - transmit-on opcode pulses transmit-on strobe
// - conditional transmit strobe, radio checks channel
// - radio-off opcode pulses radio-off strobe
// - receive flush opcode pulses receive flush strobe
// - transmit flush opcode pulses transmit flush strobe
// - ack opcode pulses ack strobe
// - ack-pending opcode pulses ack-pending strobe
// - immediate halt stops and clears everything
// - immediate start runs from pc zero
// - immediate tx calibrate strobes, waits acknowledge
module rsie_exec #(
	parameter DEPTH = 24,
	parameter AW = 5
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// host instruction port
	input wire host_load,
	input wire host_immediate,
	input wire [7:0] host_instr,
	// radio acknowledge
	input wire radio_ack,
	// unimplemented opcode completion from sibling units
	input wire other_done,
	// status
	output reg running_q,
	output reg busy_q,
	output reg [AW-1:0] pc_q,
	output reg label_valid_q,
	output reg processor_stopped_flag,
	output reg other_exec_q,
	// radio strobes
	output reg tx_synth_calibrate_strobe,
	output reg receive_on_strobe_out,
	output reg transmit_on_strobe,
	output reg conditional_transmit_strobe,
	output reg radio_off_strobe,
	output reg receive_flush_strobe,
	output reg transmit_flush_strobe,
	output reg ack_frame_strobe,
	output reg ack_pending_frame_strobe
);
	// ==========================================
	// states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_FETCH = 4'b0010;
	localparam [3:0] ST_WAIT = 4'b0100;
	localparam [3:0] ST_OTHER = 4'b1000;

	reg [3:0] state_q, state_d;
	reg [AW-1:0] pc_d;
	reg run_d, stop_d, clear_mem;
	reg fire_d, imm_wait_q, imm_wait_d;
	reg label_d;
	wire [7:0] rd_data;
	wire prg_strobe, imm_strobe;
	wire [`RSIE_STRB_W-1:0] prg_vec, imm_vec;
	reg [`RSIE_STRB_W-1:0] strb_d;
	reg fetch_ok;

	// immediates never reach memory
	wire mem_wr = host_load && !host_immediate;
	wire imm = host_load && host_immediate;

	// ==========================================
	// memory and decoders
	rsie_imem #(.DEPTH(DEPTH), .AW(AW)) u_imem (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(mem_wr),
		.wr_data(host_instr),
		.clear(clear_mem),
		.rd_addr(pc_q),
		.rd_data(rd_data),
		.count()
	);

	rsie_strobe_dec u_prg_dec (
		.opcode(rd_data),
		.is_strobe(prg_strobe),
		.strobe_vec(prg_vec)
	);

	rsie_strobe_dec u_imm_dec (
		.opcode(host_instr),
		.is_strobe(imm_strobe),
		.strobe_vec(imm_vec)
	);

	// ==========================================
	// sequencing
	always @* begin
		state_d = state_q;
		pc_d = pc_q;
		run_d = running_q;
		stop_d = 1'b0;
		clear_mem = 1'b0;
		label_d = label_valid_q;
		strb_d = {`RSIE_STRB_W{1'b0}};
		imm_wait_d = imm_wait_q;
		fire_d = 1'b0;
		fetch_ok = 1'b0;
		case (state_q)
		ST_IDLE: begin
			fetch_ok = running_q;
		end
		ST_FETCH: begin
			fetch_ok = 1'b1;
		end
		ST_WAIT: begin
			if (radio_ack) begin
				if (imm_wait_q) begin
					imm_wait_d = 1'b0;
					state_d = running_q ? ST_FETCH : ST_IDLE;
				end else begin
					pc_d = pc_q + {{(AW-1){1'b0}}, 1'b1};
					state_d = ST_FETCH;
				end
			end
		end
		ST_OTHER: begin
			// sibling units own the pc while busy
			if (other_done) begin
				pc_d = pc_q + {{(AW-1){1'b0}}, 1'b1};
				state_d = ST_FETCH;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase

		// immediates take priority over the program step
		if (imm && host_instr == `RSIE_OP_IHALT) begin
			run_d = 1'b0;
			pc_d = {AW{1'b0}};
			clear_mem = 1'b1;
			label_d = 1'b0;
			stop_d = 1'b1;
			imm_wait_d = 1'b0;
			state_d = ST_IDLE;
		end else if (imm && host_instr == `RSIE_OP_ISTART) begin
			pc_d = {AW{1'b0}};
			run_d = 1'b1;
			state_d = ST_FETCH;
		end else if (imm && imm_strobe && state_q != ST_WAIT) begin
			strb_d = imm_vec;
			imm_wait_d = 1'b1;
			state_d = ST_WAIT;
		end else if (fetch_ok && running_q) begin
			if (rd_data == `RSIE_OP_HALT) begin
				run_d = 1'b0;
				pc_d = {AW{1'b0}};
				clear_mem = 1'b1;
				label_d = 1'b0;
				stop_d = 1'b1;
				state_d = ST_IDLE;
			end else if (rd_data == `RSIE_OP_NOP) begin
				pc_d = pc_q + {{(AW-1){1'b0}}, 1'b1};
				state_d = ST_FETCH;
			end else if (prg_strobe) begin
				strb_d = prg_vec;
				state_d = ST_WAIT;
			end else begin
				fire_d = 1'b1;
				state_d = ST_OTHER;
			end
		end
	end

	// ==========================================
	// registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			pc_q <= {AW{1'b0}};
			running_q <= 1'b0;
			busy_q <= 1'b0;
			label_valid_q <= 1'b0;
			processor_stopped_flag <= 1'b0;
			other_exec_q <= 1'b0;
			imm_wait_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			running_q <= run_d;
			busy_q <= (state_d == ST_WAIT) || (state_d == ST_OTHER);
			label_valid_q <= label_d;
			// one-cycle pulse per halt
			processor_stopped_flag <= stop_d;
			other_exec_q <= fire_d;
			imm_wait_q <= imm_wait_d;
		end
	end

	// ==========================================
	// strobe outputs
	// kept apart so each strobe is a bare flop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_synth_calibrate_strobe <= 1'b0;
			receive_on_strobe_out <= 1'b0;
			transmit_on_strobe <= 1'b0;
			conditional_transmit_strobe <= 1'b0;
			radio_off_strobe <= 1'b0;
			receive_flush_strobe <= 1'b0;
			transmit_flush_strobe <= 1'b0;
			ack_frame_strobe <= 1'b0;
			ack_pending_frame_strobe <= 1'b0;
		end else begin
			tx_synth_calibrate_strobe <= strb_d[`RSIE_SB_TXCAL];
			receive_on_strobe_out <= strb_d[`RSIE_SB_RXON];
			transmit_on_strobe <= strb_d[`RSIE_SB_TXON];
			// channel check done by radio
			conditional_transmit_strobe <= strb_d[`RSIE_SB_TXCCA];
			radio_off_strobe <= strb_d[`RSIE_SB_OFF];
			receive_flush_strobe <= strb_d[`RSIE_SB_FLRX];
			transmit_flush_strobe <= strb_d[`RSIE_SB_FLTX];
			ack_frame_strobe <= strb_d[`RSIE_SB_ACK];
			ack_pending_frame_strobe <= strb_d[`RSIE_SB_ACKP];
		end
	end
endmodule

//--- verification/rsie_chk.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the exec block
module rsie_chk #(
	parameter AW = 5
) (
	input wire clk,
	input wire rst_n,
	input wire host_load,
	input wire host_immediate,
	input wire [7:0] host_instr,
	input wire radio_ack,
	input wire running_q,
	input wire busy_q,
	input wire [AW-1:0] pc_q,
	input wire label_valid_q,
	input wire processor_stopped_flag,
	input wire tx_synth_calibrate_strobe,
	input wire receive_on_strobe_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire s = tx_synth_calibrate_strobe | receive_on_strobe_out;
	wire imm = host_load && host_immediate;
	chk_strobe_one_cycle:
	assert property (s |=> !s) else $error("strobe too wide");
	chk_strobe_sets_busy:
	assert property (s |-> busy_q) else $error("strobe without busy");
	chk_pc_held_wait:
	assert property (busy_q && !radio_ack && !host_load |=> $stable(pc_q))
		else $error("pc moved while waiting");
	chk_ack_steps_pc:
	assert property (busy_q && radio_ack && running_q && !host_load |=>
		pc_q == $past(pc_q) + 1'b1) else $error("pc not stepped on ack");
	chk_halt_state:
	assert property (processor_stopped_flag |-> !running_q && pc_q == 0 &&
		!label_valid_q) else $error("halt state wrong");
	chk_imm_halt_flag:
	assert property (imm && host_instr == 8'hff |=> processor_stopped_flag &&
		!running_q) else $error("immediate halt missed");
	chk_imm_start_pc:
	assert property (imm && host_instr == 8'hfe |=> running_q && pc_q == 0)
		else $error("immediate start wrong");
	chk_imm_txcal_pulse:
	assert property (imm && host_instr == 8'he1 && !busy_q && !running_q |=>
		tx_synth_calibrate_strobe && busy_q) else $error("txcal missed");
endmodule
bind rsie_exec rsie_chk #(.AW(AW)) u_chk (.clk(clk), .rst_n(rst_n),
	.host_load(host_load), .host_immediate(host_immediate),
	.host_instr(host_instr), .radio_ack(radio_ack), .running_q(running_q),
	.busy_q(busy_q), .pc_q(pc_q), .label_valid_q(label_valid_q),
	.processor_stopped_flag(processor_stopped_flag),
	.tx_synth_calibrate_strobe(tx_synth_calibrate_strobe),
	.receive_on_strobe_out(receive_on_strobe_out));

//--- verification/rsie_radio.sv
`timescale 1ns/1ps
// ==========================================
// radio side: acks each strobe after dly idle cycles
module rsie_radio (
	input wire clk,
	input wire rst_n,
	input wire [8:0] strb,
	input wire [7:0] dly,
	output reg ack
);
	reg [7:0] cnt_q;
	reg wait_q;
	always @(posedge clk or negedge rst_n) begin
		ack <= 1'b0;
		if (!rst_n) begin
			wait_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (|strb) begin
			wait_q <= 1'b1;
			cnt_q <= dly;
		end else if (wait_q && cnt_q == 8'h00) begin
			wait_q <= 1'b0;
			ack <= 1'b1;
		end else if (wait_q) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

//--- verification/radio_strobe_instruction_exec_tb.sv
`timescale 1ns/1ps
module radio_strobe_instruction_exec_tb;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg host_load = 1'b0;
	reg host_immediate = 1'b0;
	reg [7:0] host_instr = 8'h00;
	reg [7:0] dly = 8'h00;
	wire radio_ack, running_q, busy_q, label_valid_q, processor_stopped_flag;
	wire other_exec_q;
	wire [4:0] pc_q;
	wire [8:0] sv;
	integer miscompares = 0;
	integer check_count = 0;
	integer i;
	int log_q[$];
	always #2 clk = ~clk;
	// strobe order log, one-hot index
	always @(posedge clk) if (|sv) log_q.push_back($clog2(sv));
	rsie_exec uut (.clk(clk), .rst_n(rst_n), .host_load(host_load),
		.host_immediate(host_immediate), .host_instr(host_instr),
		.radio_ack(radio_ack), .other_done(1'b0), .running_q(running_q),
		.busy_q(busy_q), .pc_q(pc_q), .label_valid_q(label_valid_q),
		.processor_stopped_flag(processor_stopped_flag),
		.other_exec_q(other_exec_q),
		.tx_synth_calibrate_strobe(sv[0]), .receive_on_strobe_out(sv[1]),
		.transmit_on_strobe(sv[2]), .conditional_transmit_strobe(sv[3]),
		.radio_off_strobe(sv[4]), .receive_flush_strobe(sv[5]),
		.transmit_flush_strobe(sv[6]), .ack_frame_strobe(sv[7]),
		.ack_pending_frame_strobe(sv[8]));
	rsie_radio radio (.clk(clk), .rst_n(rst_n), .strb(sv), .dly(dly),
		.ack(radio_ack));
	task chk(input [31:0] seen, input [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task issue(input [7:0] op, input imm);
		@(posedge clk) #1;
		host_load = 1'b1;
		host_immediate = imm;
		host_instr = op;
		@(posedge clk) #1;
		host_load = 1'b0;
	endtask
	task wait_flag;
		integer n;
		for (n = 0; n < 400 && processor_stopped_flag !== 1'b1; n = n + 1)
			@(posedge clk) #1;
		chk(processor_stopped_flag, 1'b1);
		chk({running_q, pc_q, label_valid_q}, 7'h00);
	endtask
	task wait_idle;
		integer n;
		repeat (2) @(posedge clk);
		#1;
		for (n = 0; n < 100 && busy_q !== 1'b0; n = n + 1)
			@(posedge clk) #1;
		chk(busy_q, 1'b0);
	endtask
	// nop then every program strobe, ending in halt
	task t_program;
		dly = 8'h03;
		// radio model stands for turnaround disable set
		for (i = 0; i < 10; i = i + 1)
			issue(8'hc0 + i, 1'b0);
		issue(8'hdf, 1'b0);
		log_q.delete();
		issue(8'hfe, 1'b1);
		wait_flag();
		chk(log_q.size(), 9);
		for (i = 0; i < 9; i = i + 1)
			chk(log_q[i], i);
	endtask
	// each immediate strobe, then a refused one while waiting
	task t_immediate;
		dly = 8'h00;
		for (i = 0; i < 9; i = i + 1) begin
			log_q.delete();
			issue(8'he1 + i, 1'b1);
			wait_idle();
			chk(log_q.size(), 1);
			chk(log_q[0], i);
		end
		dly = 8'h14;
		log_q.delete();
		issue(8'he2, 1'b1);
		issue(8'he3, 1'b1);
		wait_idle();
		chk(log_q.size(), 1);
		chk(log_q[0], 1);
	endtask
	// halt while waiting, then restart finds memory empty
	task t_halt_clears;
		dly = 8'h32;
		issue(8'hc2, 1'b0);
		issue(8'hc3, 1'b0);
		issue(8'hfe, 1'b1);
		repeat (4) @(posedge clk);
		issue(8'hff, 1'b1);
		wait_flag();
		dly = 8'h00;
		// non-strobe opcode goes to the sibling and holds the pc
		issue(8'hba, 1'b0);
		issue(8'hfe, 1'b1);
		@(posedge clk) #1;
		chk(other_exec_q, 1'b1);
		chk({busy_q, pc_q}, 6'h20);
		issue(8'hff, 1'b1);
		wait_flag();
		repeat (60) @(posedge clk);
		log_q.delete();
		issue(8'hfe, 1'b1);
		wait_flag();
		chk(log_q.size(), 0);
	endtask
	task report_and_stop;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares = miscompares + 1;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_program();
		t_immediate();
		t_halt_clears();
		report_and_stop();
	end
endmodule
